// >>> rtl/dae_engine.sv
`timescale 1ns/10ps
// Contract
// - xor store is one atomic read-modify-write
// - operand size follows the store size
// - xor decode: bits 30:29 10, 28:26 011
// - xor target is base plus 20-bit offset
// - cycle x: strip, decode, read, capture
// - cycle x+1: reissue captured address as write
// - x+1 data: register read data xor operand
// - x+2 data: drive registered value as write
// - insert w+1 bits starting at b
// - word inserts at most 16 bits wide
// - insert decode: 28 set, b, w, offset
// - insert uses bit 19 as width bit
// - width code zero inserts one bit
// - field truncated at the container edge
// - x+1 data: mask merge, register result
// - master stalled during first data phase
// - slave wait states passed back cycle for cycle
module dae_engine
    import dae_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [31:0] M_HADDR,
    input wire logic [1:0] M_HTRANS,
    input wire logic M_HWRITE,
    input wire logic [2:0] M_HSIZE,
    input wire logic [31:0] M_HWDATA,
    output logic [31:0] M_HRDATA,
    output logic M_HREADY,
    output logic M_HRESP,
    output logic [31:0] S_HADDR,
    output logic [1:0] S_HTRANS,
    output logic S_HWRITE,
    output logic [2:0] S_HSIZE,
    output logic [31:0] S_HWDATA,
    input wire logic [31:0] S_HRDATA,
    input wire logic S_HREADY,
    input wire logic S_HRESP
);

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    dae_regs_t r_reg;       // all state of the engine
    dae_regs_t r_next;      // next value of the state
    logic in_space;         // address lies in the decorated peripheral window
    logic is_xor;           // xor store decoration
    logic is_fi;            // field insert store decoration
    logic dec_req;          // a decorated store offered in its address phase
    logic [31:0] strip_adr; // real target address with the decoration removed
    logic [31:0] mod_mask;  // lane-placed insert mask
    logic [31:0] mod_res;   // modified value for the write back
    dae_aphase_t ds;        // downstream address phase
    logic [31:0] ds_wdata;  // downstream write data
    logic up_ready;         // ready returned to the master

    // the decoration only ever marks a write; a decorated read is not handled here
    always_comb begin
        in_space = (M_HADDR[DAE_TOP_BIT] == 1'b0)
                   && (M_HADDR[DAE_SPACE_HI:DAE_SPACE_LO] == DAE_SPACE_PERIPH);
        is_fi = in_space && M_HADDR[DAE_FI_BIT];
        is_xor = in_space && (M_HADDR[DAE_OP_HI:DAE_OP_LO] == DAE_OP_XOR);
        dec_req = M_HTRANS[1] && M_HWRITE && (is_fi || is_xor);
        if (is_fi) begin
            // bit 19 belongs to the width field here, not to the offset
            strip_adr = DAE_PERIPH_BASE | {13'h0000, M_HADDR[DAE_FI_OFS_HI:0]};
        end else begin
            strip_adr = DAE_PERIPH_BASE | {12'h000, M_HADDR[DAE_XOR_OFS_HI:0]};
        end
    end

    // ----------------------------------------------------------------
    // modify unit
    // ----------------------------------------------------------------
    // the operand is read straight off the stalled master write data bus
    dae_modify dae_modify_i (
        .kind(r_reg.kind),
        .hsize(r_reg.cap.hsize),
        .lane(r_reg.cap.haddr[1:0]),
        .lsb(r_reg.lsb),
        .wm1(r_reg.wm1),
        .rdata(S_HRDATA),
        .wdata(M_HWDATA),
        .mask(mod_mask),
        .result(mod_res)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // address phase logic stays combinational so plain traffic sees no added latency
    always_comb begin
        r_next = r_reg;
        ds.haddr = M_HADDR;
        ds.htrans = M_HTRANS;
        ds.hwrite = M_HWRITE;
        ds.hsize = M_HSIZE;
        ds_wdata = M_HWDATA;
        up_ready = S_HREADY;
        case (r_reg.state)
            DAE_ST_PASS, DAE_ST_WRITE: begin
                // a write back in progress sources the registered value
                if (r_reg.state == DAE_ST_WRITE) begin
                    ds_wdata = r_reg.result;
                end
                // a decorated store leaves as a read of the real address
                if (dec_req) begin
                    ds.haddr = strip_adr;
                    ds.hwrite = 1'b0;
                end
                // address phases only complete while the slave is ready
                if (S_HREADY) begin
                    if (dec_req) begin
                        r_next.state = DAE_ST_READ;
                        r_next.kind = is_fi ? DAE_KIND_FI : DAE_KIND_XOR;
                        r_next.cap = ds;
                        r_next.cap.hwrite = 1'b1;
                        r_next.lsb = M_HADDR[DAE_FI_LSB_HI:DAE_FI_LSB_LO];
                        r_next.wm1 = M_HADDR[DAE_FI_WM1_HI:DAE_FI_WM1_LO];
                    end else begin
                        r_next.state = DAE_ST_PASS;
                    end
                end
            end
            DAE_ST_READ: begin
                // recirculate the captured address as the write
                ds = r_reg.cap;
                ds.htrans = DAE_HTRANS_NONSEQ;
                up_ready = 1'b0;
                // waits stretch this phase; the result is taken on the ready cycle
                if (S_HREADY) begin
                    r_next.result = mod_res;
                    r_next.state = DAE_ST_WRITE;
                end
            end
            default: begin
                r_next = DAE_REGS_RESET;
            end
        endcase
    end

    // the only flip-flops of the engine
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_reg <= DAE_REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // port drive
    // ----------------------------------------------------------------
    // slave errors are passed through unchanged; the write back is not cancelled
    assign S_HADDR = ds.haddr;
    assign S_HTRANS = ds.htrans;
    assign S_HWRITE = ds.hwrite;
    assign S_HSIZE = ds.hsize;
    assign S_HWDATA = ds_wdata;
    assign M_HRDATA = S_HRDATA;
    assign M_HREADY = up_ready;
    assign M_HRESP = S_HRESP;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking dae_cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    chk_xor_strip_read:
    assert property ((r_reg.state != DAE_ST_READ) && M_HTRANS[1] && M_HWRITE
                     && !M_HADDR[31] && (M_HADDR[30:26] == 5'h13)
                     |-> !S_HWRITE && (S_HADDR == {12'h400, M_HADDR[19:0]}))
        else $error("xor store not forwarded as stripped read");

    chk_fi_strip_read:
    assert property ((r_reg.state != DAE_ST_READ) && M_HTRANS[1] && M_HWRITE
                     && (M_HADDR[31:28] == 4'h5)
                     |-> !S_HWRITE && (S_HADDR == {13'h0800, M_HADDR[18:0]}))
        else $error("insert store not forwarded as stripped read");

    chk_recirc_write:
    assert property ((r_reg.state != DAE_ST_READ) && dec_req && S_HREADY
                     |=> S_HWRITE && (S_HTRANS == DAE_HTRANS_NONSEQ)
                         && (S_HADDR == $past(strip_adr)))
        else $error("write phase does not reuse captured address");

    chk_master_stall:
    assert property ((r_reg.state != DAE_ST_READ) && dec_req && S_HREADY
                     |=> !M_HREADY)
        else $error("master not stalled during read data phase");

    chk_xor_result:
    assert property ((r_reg.state == DAE_ST_READ) && (r_reg.kind == DAE_KIND_XOR) && S_HREADY
                     |=> (S_HWDATA == ($past(S_HRDATA) ^ $past(M_HWDATA))))
        else $error("xor write data wrong");

    chk_fi_merge:
    assert property ((r_reg.state == DAE_ST_READ) && (r_reg.kind == DAE_KIND_FI) && S_HREADY
                     |=> (((S_HWDATA ^ $past(S_HRDATA)) & ~$past(mod_mask)) == 32'h0000_0000)
                         && (((S_HWDATA ^ $past(M_HWDATA)) & $past(mod_mask)) == 32'h0000_0000))
        else $error("insert write data merged wrongly");

    chk_fi_one_bit:
    assert property ((r_reg.state == DAE_ST_READ) && (r_reg.kind == DAE_KIND_FI)
                     && (r_reg.wm1 == 4'h0) && (r_reg.lsb < 5'h08)
                     |-> $onehot(mod_mask))
        else $error("zero width code did not select one bit");

    chk_fi_container:
    assert property ((r_reg.state == DAE_ST_READ) && (r_reg.kind == DAE_KIND_FI)
                     && (r_reg.cap.hsize == DAE_HSIZE_BYTE) && (r_reg.cap.haddr[1:0] == 2'h0)
                     |-> ((mod_mask & 32'hFFFF_FF00) == 32'h0000_0000)
                         && ($countones(mod_mask) <= 16))
        else $error("insert mask leaves the container");

    chk_wait_pass:
    assert property ((r_reg.state == DAE_ST_READ) && !S_HREADY
                     |=> (r_reg.state == DAE_ST_READ) && !M_HREADY)
        else $error("slave wait not reflected to master");

    chk_plain_pass:
    assert property ((r_reg.state == DAE_ST_PASS) && !dec_req
                     |-> (S_HADDR == M_HADDR) && (S_HWRITE == M_HWRITE) && (M_HREADY == S_HREADY))
        else $error("plain access altered or stalled");

endmodule // dae_engine

// >>> rtl/dae_pkg.sv
package dae_pkg;

    // ----------------------------------------------------------------
    // address decoration fields
    // ----------------------------------------------------------------
    localparam logic [31:0] DAE_PERIPH_BASE = 32'h4000_0000; // base of the real target space
    localparam int DAE_TOP_BIT = 31;          // must be clear on a decorated access
    localparam int DAE_SPACE_HI = 30;         // space select, upper bit
    localparam int DAE_SPACE_LO = 29;         // space select, lower bit
    localparam logic [1:0] DAE_SPACE_PERIPH = 2'h2; // peripheral space code
    localparam int DAE_OP_HI = 28;            // operation code, upper bit
    localparam int DAE_OP_LO = 26;            // operation code, lower bit
    localparam logic [2:0] DAE_OP_XOR = 3'h3; // exclusive-or store code
    localparam int DAE_FI_BIT = 28;           // set for a field insert store
    localparam int DAE_FI_LSB_HI = 27;        // field start position, upper bit
    localparam int DAE_FI_LSB_LO = 23;        // field start position, lower bit
    localparam int DAE_FI_WM1_HI = 22;        // field width minus one, upper bit
    localparam int DAE_FI_WM1_LO = 19;        // field width minus one, lower bit
    localparam int DAE_XOR_OFS_HI = 19;       // top bit of the xor store offset
    localparam int DAE_FI_OFS_HI = 18;        // top bit of the field insert offset

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] DAE_HTRANS_IDLE = 2'h0;   // no transfer
    localparam logic [1:0] DAE_HTRANS_NONSEQ = 2'h2; // single transfer
    localparam logic [2:0] DAE_HSIZE_BYTE = 3'h0;    // 8-bit transfer
    localparam logic [2:0] DAE_HSIZE_HALF = 3'h1;    // 16-bit transfer
    localparam logic [31:0] DAE_CONT_BYTE = 32'h0000_00FF; // byte container
    localparam logic [31:0] DAE_CONT_HALF = 32'h0000_FFFF; // halfword container
    localparam logic [31:0] DAE_CONT_WORD = 32'hFFFF_FFFF; // word container
    localparam logic [4:0] DAE_WIDTH_TOP = 5'h1F;  // shift base for the field ones

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DAE_ST_PASS = 2'h0,  // plain pass-through, decode new requests
        DAE_ST_READ = 2'h1,  // read data phase, write address phase out
        DAE_ST_WRITE = 2'h3  // write data phase of the modified value
    } dae_state_t;

    typedef enum logic {
        DAE_KIND_XOR = 1'h0, // exclusive-or store
        DAE_KIND_FI = 1'h1   // field insert store
    } dae_kind_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
    } dae_aphase_t;

    typedef struct packed {
        dae_state_t state;
        dae_kind_t kind;
        dae_aphase_t cap;
        logic [4:0] lsb;
        logic [3:0] wm1;
        logic [31:0] result;
    } dae_regs_t;

    localparam dae_regs_t DAE_REGS_RESET = '0; // idle, nothing captured

endpackage

// >>> rtl/dae_modify.sv
`timescale 1ns/10ps
module dae_modify
    import dae_pkg::*;
(
    input wire dae_kind_t kind,
    input wire logic [2:0] hsize,
    input wire logic [1:0] lane,
    input wire logic [4:0] lsb,
    input wire logic [3:0] wm1,
    input wire logic [31:0] rdata,
    input wire logic [31:0] wdata,
    output logic [31:0] mask,
    output logic [31:0] result
);

    // ----------------------------------------------------------------
    // field mask
    // ----------------------------------------------------------------
    logic [31:0] ones;  // wm1+1 low ones
    logic [31:0] cont;  // right-aligned container of the access size
    logic [31:0] fmask; // field mask inside the container

    // the mask is cut at the container edge, so an overlong field keeps only its low bits
    always_comb begin
        // a 4-bit width code caps every field at 16 bits, word stores included
        ones = DAE_CONT_WORD >> (DAE_WIDTH_TOP - {1'b0, wm1});
        if (hsize == DAE_HSIZE_BYTE) begin
            cont = DAE_CONT_BYTE;
        end else if (hsize == DAE_HSIZE_HALF) begin
            cont = DAE_CONT_HALF;
        end else begin
            cont = DAE_CONT_WORD;
        end
        fmask = (ones << lsb) & cont;
        // the master replicates narrow data on every lane, so moving the mask
        // onto the addressed lane is all the alignment needed
        mask = fmask << {lane, 3'h0};
    end

    // ----------------------------------------------------------------
    // per-bit merge
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            // insert takes the operand under the mask, xor flips by the operand
            assign result[i] = (kind == DAE_KIND_FI) ? (mask[i] ? wdata[i] : rdata[i])
                                                     : (rdata[i] ^ wdata[i]);
        end
    endgenerate

endmodule // dae_modify

// >>> verification/dae_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far-side peripheral slave: word memory with programmable waits
// ----------------------------------------------------------------
module dae_slave_model
    import dae_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic [3:0] wait_cycles,
    output logic [31:0] hrdata,
    output logic hready,
    output logic hresp
);
    logic [31:0] mem [0:63]; // words picked by offset bits 7:2, preloaded by the bench
    logic dp_valid; // a data phase is open
    logic dp_write; // open data phase is a write
    logic [31:0] dp_addr; // address of the open data phase
    logic [2:0] dp_size; // size of the open data phase
    logic [3:0] wcnt; // waits still owed in this data phase
    logic [31:0] noise; // moves every cycle so stale read data never looks right
    logic [31:0] lm; // byte lanes touched by the open data phase
    assign hresp = 1'b0; // never answers with an error
    assign hready = !(dp_valid && wcnt != 4'h0);
    assign hrdata = (dp_valid && !dp_write && hready) ? mem[dp_addr[7:2]] : noise;
    assign lm = (dp_size == DAE_HSIZE_BYTE) ? DAE_CONT_BYTE << (8 * dp_addr[1:0])
        : (dp_size == DAE_HSIZE_HALF) ? DAE_CONT_HALF << (16 * dp_addr[1]) : DAE_CONT_WORD;
    // plain always, not always_ff: the bench also writes mem to preload it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid <= 1'b0;
            wcnt <= 4'h0;
            noise <= 32'hA5C3_5A3C;
        end else begin
            noise <= {noise[30:0], ~noise[31]};
            if (hready) begin
                // a write lands at the end of its data phase, only in its own lanes
                if (dp_valid && dp_write) begin
                    mem[dp_addr[7:2]] <= (mem[dp_addr[7:2]] & ~lm) | (hwdata & lm);
                end
                dp_valid <= htrans[1];
                dp_write <= hwrite;
                dp_addr <= haddr;
                dp_size <= hsize;
                wcnt <= wait_cycles;
            end else begin
                wcnt <= wcnt - 4'h1;
            end
        end
    end
endmodule // dae_slave_model

// >>> verification/dae_engine_tb.sv
`timescale 1ns/10ps
module dae_engine_tb
    import dae_pkg::*;
;
    // ----------------------------------------------------------------
    // nets, counters and the batch table
    // ----------------------------------------------------------------
    logic clk;
    logic rst_n;
    logic [31:0] m_haddr, m_hwdata, m_hrdata, s_haddr, s_hwdata, s_hrdata;
    logic [1:0] m_htrans, s_htrans;
    logic [2:0] m_hsize, s_hsize;
    logic m_hwrite, m_hready, m_hresp, s_hwrite, s_hready, s_hresp;
    logic [3:0] wait_cycles; // slave waits per data phase
    int num_errors;
    int comparisons;
    logic [31:0] last_rd; // read data of the latest transfer
    logic [31:0] ta [8]; // batch: decorated address
    logic [31:0] twd [8]; // batch: operand as put on the bus
    logic [2:0] tsz [8]; // batch: store size
    int nb; // entries in the batch
    dae_engine dae_engine_i (.CLK(clk), .RESETN(rst_n), .M_HADDR(m_haddr),
        .M_HTRANS(m_htrans), .M_HWRITE(m_hwrite), .M_HSIZE(m_hsize), .M_HWDATA(m_hwdata),
        .M_HRDATA(m_hrdata), .M_HREADY(m_hready), .M_HRESP(m_hresp), .S_HADDR(s_haddr),
        .S_HTRANS(s_htrans), .S_HWRITE(s_hwrite), .S_HSIZE(s_hsize), .S_HWDATA(s_hwdata),
        .S_HRDATA(s_hrdata), .S_HREADY(s_hready), .S_HRESP(s_hresp));
    dae_slave_model dae_slave_model_i (.clk(clk), .rst_n(rst_n), .haddr(s_haddr),
        .htrans(s_htrans), .hwrite(s_hwrite), .hsize(s_hsize), .hwdata(s_hwdata),
        .wait_cycles(wait_cycles), .hrdata(s_hrdata), .hready(s_hready), .hresp(s_hresp));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("TB: mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [31:0] cont(input logic [2:0] sz); // container of a size
        if (sz == DAE_HSIZE_BYTE) return DAE_CONT_BYTE;
        if (sz == DAE_HSIZE_HALF) return DAE_CONT_HALF;
        return DAE_CONT_WORD;
    endfunction
    function automatic int shamt(input logic [2:0] sz, input logic [1:0] lo); // lane offset
        if (sz == DAE_HSIZE_BYTE) return 8 * lo;
        if (sz == DAE_HSIZE_HALF) return 16 * lo[1];
        return 0;
    endfunction
    function automatic logic [31:0] pre(input int i); // distinct old contents per entry
        return 32'h9C3A_61E5 + 32'h0101_0101 * i;
    endfunction
    // samples at falling edges, so the ready seen is the one the next rising edge uses
    task automatic wait_ready(output int n, output logic [31:0] fa, output logic [2:0] fw);
        n = 0;
        @(negedge clk);
        fa = s_haddr;
        fw = {s_hwrite, s_htrans};
        while (m_hready !== 1'b1) begin
            n++;
            if (n > 40) begin
                num_errors++;
                end_sim();
            end
            @(negedge clk);
        end
    endtask
    // one master transfer; no trailing edge, so calls run back to back
    task automatic op(input logic [31:0] a, input logic wr, input logic [2:0] sz,
        input logic [31:0] wd, input logic [31:0] ea, input logic dec, input int est);
        int n;
        logic [31:0] fa;
        logic [2:0] fw;
        @(posedge clk);
        m_haddr <= a;
        m_htrans <= DAE_HTRANS_NONSEQ;
        m_hwrite <= wr;
        m_hsize <= sz;
        wait_ready(n, fa, fw);
        check32(fa, ea, "address in first phase");
        check32(fw, {wr & ~dec, DAE_HTRANS_NONSEQ}, "first phase kind");
        @(posedge clk);
        m_htrans <= DAE_HTRANS_IDLE;
        m_hwdata <= wd;
        wait_ready(n, fa, fw);
        last_rd = m_hrdata;
        check32(n, est, "master stall cycles");
        check32({31'h0, m_hresp}, 32'h0, "okay response passed back");
        if (dec) begin
            check32(fa, ea, "address in second phase");
            check32(fw, {1'b1, DAE_HTRANS_NONSEQ}, "second phase kind");
        end
    endtask
    task automatic add(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] v);
        ta[nb] = a;
        tsz[nb] = sz;
        twd[nb] = (sz == DAE_HSIZE_BYTE) ? {4{v[7:0]}}
            : (sz == DAE_HSIZE_HALF) ? {2{v[15:0]}} : v;
        nb++;
    endtask
    // preload, issue the batch back to back, then compare what the slave holds
    task automatic run_batch(input int est);
        logic [31:0] ea;
        logic [31:0] m;
        logic [63:0] f;
        logic [31:0] nv;
        for (int i = 0; i < nb; i++) begin
            dae_slave_model_i.mem[ta[i][7:2]] = pre(i);
        end
        for (int i = 0; i < nb; i++) begin
            ea = DAE_PERIPH_BASE | (ta[i][28] ? {13'h0, ta[i][18:0]} : {12'h0, ta[i][19:0]});
            op(ta[i], 1'b1, tsz[i], twd[i], ea, 1'b1, est);
        end
        @(negedge clk);
        for (int i = 0; i < nb; i++) begin
            f = ((64'h1 << (ta[i][22:19] + 1)) - 64'h1) << ta[i][27:23];
            m = (f[31:0] & cont(tsz[i])) << shamt(tsz[i], ta[i][1:0]);
            nv = ta[i][28] ? (pre(i) & ~m) | (twd[i] & m) : pre(i) ^ twd[i];
            m = cont(tsz[i]) << shamt(tsz[i], ta[i][1:0]);
            nv = pre(i) ^ ((pre(i) ^ nv) & m);
            check32(dae_slave_model_i.mem[ta[i][7:2]], nv, "stored result");
        end
        nb = 0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_plain(input logic [3:0] w); // the read is a decorated load: passes
        @(posedge clk);
        wait_cycles <= w;
        op(32'h4000_0040, 1'b1, 3'h2, 32'h3C5A_96E1, 32'h4000_0040, 1'b0, w);
        op(32'h4C00_0040, 1'b0, 3'h2, 32'h0, 32'h4C00_0040, 1'b0, w);
        check32(last_rd, 32'h3C5A_96E1, "plain write then read");
        $display("TB: test plain waits %0d done", w);
    endtask
    task automatic t_xor(); // don't-care bits 25:20 set, offset bit 19 set
        add(32'h4FF8_0023, DAE_HSIZE_BYTE, 32'h0000_00A5);
        add(32'h4FF8_0026, DAE_HSIZE_HALF, 32'h0000_F00F);
        add(32'h4FF8_0028, 3'h2, 32'hFFFF_0001);
        run_batch(1);
        $display("TB: test xor done");
    endtask
    task automatic t_fi(); // field already at its final place in the container
        add(32'h5000_0030, DAE_HSIZE_BYTE, 32'h0000_005E);
        add(32'h5310_0035, DAE_HSIZE_BYTE, 32'h0000_00C0);
        add(32'h5638_003A, DAE_HSIZE_HALF, 32'h0000_A5F0);
        add(32'h5A78_003C, 3'h2, 32'h5AC3_3C00);
        add(32'h51F8_0050, 3'h2, 32'h1234_5678);
        run_batch(1);
        $display("TB: test field insert done");
    endtask
    task automatic t_waits(); // two waits in every slave data phase
        @(posedge clk);
        wait_cycles <= 4'h2;
        add(32'h4C00_0044, 3'h2, 32'h0F0F_F0F0);
        add(32'h5208_0048, 3'h2, 32'h0000_0030);
        run_batch(5);
        $display("TB: test waits done");
        t_plain(4'h2);
    endtask
    // ----------------------------------------------------------------
    // clock, reset and sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        m_haddr = 32'h0;
        m_htrans = DAE_HTRANS_IDLE;
        m_hwrite = 1'b0;
        m_hsize = 3'h2;
        m_hwdata = 32'h0;
        wait_cycles = 4'h0;
        num_errors = 0;
        comparisons = 0;
        nb = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_plain(4'h0);
        t_xor();
        t_fi();
        t_waits();
        @(negedge clk);
        end_sim();
    end
endmodule // dae_engine_tb
